/* File: rtl/ums_pkg.sv */
// Shared constants and types for the master SPI transfer block
package ums_pkg;

    // Mode select value that hands the transceiver to SPI transfer control
    localparam logic [1:0] MODE_MSPI      = 2'h3;

    // Frame shape: eight data bits, two clock edges per bit
    localparam int         FRAME_BITS     = 8;
    localparam int         EDGE_W         = 4;
    localparam logic [3:0] EDGE_FIRST     = 4'h0;
    localparam logic [3:0] EDGE_LAST      = 4'hF;

    // Baud divisor width; half period of the shift clock is divisor+1 cycles
    localparam int         BAUD_W         = 12;

    // Receive buffer depth beyond the shift register
    localparam int         RX_DEPTH       = 2;

    // Reset values of the visible state
    localparam logic [7:0] DATA_RESET     = 8'h00;
    localparam logic       LINE_IDLE      = 1'b1;
    localparam logic       EMPTY_RESET    = 1'b1;

    // Transfer sequencer states
    typedef enum logic [0:0]
    {
        UMS_IDLE  = 1'b0,
        UMS_SHIFT = 1'b1
    } ums_state_type;

endpackage : ums_pkg

/* File: rtl/ums_buf.sv */
// Small valid/ready buffer used as the receive data queue
`timescale 1ns/1ps
module ums_buf
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Discard all held entries
    input  wire logic             flush,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } ums_buf_state_type;

    ums_buf_state_type cur;
    ums_buf_state_type nx;
    logic              push;
    logic              pop;

    // Pointer advance with wrap at the depth
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // Honest full and empty straight from the count
    assign in_ready  = (cur.cnt != CW'(DEPTH));
    assign out_valid = (cur.cnt != '0);
    assign out_data  = cur.mem[cur.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next state; a flush wins over any push or pop in the same cycle
    always_comb
    begin
        nx = cur;
        if (flush)
        begin
            nx.wp  = '0;
            nx.rp  = '0;
            nx.cnt = '0;
        end
        else
        begin
            if (push)
            begin
                nx.mem[cur.wp] = in_data;
                nx.wp          = ptr_inc(cur.wp);
            end
            if (pop)
            begin
                nx.rp = ptr_inc(cur.rp);
            end
            if (push && !pop)
            begin
                nx.cnt = cur.cnt + 1'b1;
            end
            else if (pop && !push)
            begin
                nx.cnt = cur.cnt - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= nx;
        end
    end

endmodule : ums_buf

/* File: rtl/ums_core.sv */
// Master-only SPI transfer engine of the serial transceiver
// Overview of operation
// RULE1: Software enables the transmitter before any transfer; output pin then carries data.
// RULE2: Optional receiver enable hands the serial input pin to the receiver.
// RULE3: Transfer clock pin is driven as shift clock, receiver enabled or not.
// RULE4: Writing the data register starts each byte, for receive and transmit.
// RULE5: Written byte enters the shift register only when a new frame can begin.
// RULE6: Software reads the data register once per byte sent to stay in step.
// RULE7: On receive overflow the newest byte is dropped, older bytes kept.
// RULE8: Receive done, transmit done and empty flags act as in normal mode.
// RULE9: Framing, overrun and parity error flags always read zero.
// RULE10: Polarity, phase and bit order bits act as on the standalone SPI unit.
// RULE11: Transmit path double buffered: one byte waits while another shifts.
// RULE12: Receive path holds a buffer level beyond the shift register.
// RULE13: No write collision flag exists in this mode.
// RULE14: No double speed bit; faster rates come from the baud divisor.
// RULE15: Master only, no slave select, interrupt timing differs.
// RULE16: Disabling transmitter or receiver behaves as in normal operation.
// RULE17: Polled software waits for empty flag, writes, then waits for receive done.
// RULE18: Mode select field at both ones selects master SPI operation.
// RULE19: Each frame is exactly eight bits, order chosen by bit order bit.
// RULE20: Data shifts on one clock edge, sampled on the opposite one.
// RULE21: After the eighth sample the byte enters the receive buffer.
`timescale 1ns/1ps
module ums_core
#(
    parameter int RX_DEPTH = ums_pkg::RX_DEPTH
)
(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // Configuration bits
    input  wire logic [1:0]                transceiver_mode_select,
    input  wire logic                      tx_enable_bit,
    input  wire logic                      rx_enable_bit,
    input  wire logic                      clock_polarity_bit,
    input  wire logic                      clock_phase_bit,
    input  wire logic                      bit_order_bit,
    input  wire logic [ums_pkg::BAUD_W-1:0] baud_divisor,
    // Data register access
    input  wire logic                      wr_strobe,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      rd_strobe,
    output logic [7:0]                     rd_data,
    // Status flags
    input  wire logic                      txc_clear,
    output logic                           data_empty_flag,
    output logic                           receive_done_flag,
    output logic                           transmit_done_flag,
    output logic                           framing_error_flag,
    output logic                           overrun_flag,
    output logic                           parity_error_flag,
    // Serial pins
    output logic                           serial_out_pin,
    output logic                           serial_out_oe,
    input  wire logic                      serial_in_pin,
    output logic                           transfer_clock_pin,
    output logic                           transfer_clock_oe
);

    typedef struct packed
    {
        ums_pkg::ums_state_type         st;
        logic [7:0]                     tx_buf;
        logic                           tx_full;
        logic [7:0]                     tx_sh;
        logic [7:0]                     rx_sh;
        logic [ums_pkg::EDGE_W-1:0]     edge_cnt;
        logic [ums_pkg::BAUD_W-1:0]     baud_cnt;
        logic [1:0]                     sin_sync;
        logic                           mosi;
        logic                           sck_pin;
        logic                           drv;
        logic                           udre;
        logic                           txc;
        logic                           rxc;
        logic [7:0]                     rd_data;
        logic                           frm_err;
        logic                           ovr_err;
        logic                           par_err;
    } ums_core_state_type;

    ums_core_state_type cur;
    ums_core_state_type nx;

    // Decoded controls and strobes of the current cycle
    logic       active;
    logic       tx_on;
    logic       rx_on;
    logic       tick;
    logic       sample_edge;
    logic       load;
    logic       frame_end;
    logic       accept;
    logic       txc_set;
    logic [7:0] rx_val;

    // Receive queue ports
    logic       rx_push;
    logic       rx_in_ready;
    logic       rx_out_valid;
    logic [7:0] rx_out_data;

    // Bit that leaves the shifter next, per bit order
    function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
        out_bit = lsb_first ? sh[0] : sh[7];
    endfunction : out_bit

    // Shift one bit in or out, per bit order
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in

    // Mode and enable decode
    assign active = (transceiver_mode_select == ums_pkg::MODE_MSPI);   // see RULE18
    assign tx_on  = active && tx_enable_bit;                            // see RULE1
    assign rx_on  = active && rx_enable_bit;                            // see RULE2
    // Divisor 0 gives half the system clock; no separate double speed bit
    assign tick   = (cur.baud_cnt == baud_divisor);                     // see RULE14
    // Even edges lead; phase 0 samples on leading, phase 1 on trailing
    assign sample_edge = (cur.edge_cnt[0] == clock_phase_bit);          // see RULE20

    // Receive queue: one level is the classic receive buffer, the second the extra one
    ums_buf
    #(
        .WIDTH (8),
        .DEPTH (RX_DEPTH)                                              // see RULE12
    )
    u_rx_buf
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .flush     (!rx_on),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_val),
        .out_valid (rx_out_valid),
        .out_ready (rd_strobe),
        .out_data  (rx_out_data)
    );

    // Transfer sequencer, buffers and flags
    always_comb
    begin
        nx          = cur;
        load        = 1'b0;
        frame_end   = 1'b0;
        accept      = 1'b0;
        rx_val      = cur.rx_sh;
        // Input pin reaches logic only through both synchroniser stages
        nx.sin_sync = {cur.sin_sync[0], serial_in_pin};

        case (cur.st)
            ums_pkg::UMS_IDLE:
            begin
                nx.baud_cnt = '0;
                nx.sck_pin  = clock_polarity_bit;                       // see RULE10
                // A queued byte moves over only between frames
                if (active && cur.tx_full)                              // see RULE5
                begin
                    load        = 1'b1;
                    nx.tx_sh    = cur.tx_buf;
                    nx.tx_full  = 1'b0;
                    nx.edge_cnt = ums_pkg::EDGE_FIRST;
                    nx.st       = ums_pkg::UMS_SHIFT;
                end
            end
            ums_pkg::UMS_SHIFT:
            begin
                if (!active)
                begin
                    // Leaving the mode abandons the frame
                    nx.st = ums_pkg::UMS_IDLE;
                end
                else if (tick)
                begin
                    nx.baud_cnt = '0;
                    nx.sck_pin  = !cur.sck_pin;                         // see RULE3
                    if (sample_edge)
                    begin
                        rx_val   = shift_in(cur.rx_sh, cur.sin_sync[1], bit_order_bit);
                        nx.rx_sh = rx_val;                              // see RULE20
                    end
                    else if (cur.edge_cnt != ums_pkg::EDGE_FIRST)
                    begin
                        // First setup edge of phase 1 presents bit 0 unshifted
                        nx.tx_sh = shift_in(cur.tx_sh, 1'b0, bit_order_bit);
                    end
                    if (cur.edge_cnt == ums_pkg::EDGE_LAST)             // see RULE19
                    begin
                        frame_end = 1'b1;
                        nx.st     = ums_pkg::UMS_IDLE;
                    end
                    else
                    begin
                        nx.edge_cnt = cur.edge_cnt + 1'b1;
                    end
                end
                else
                begin
                    nx.baud_cnt = cur.baud_cnt + 1'b1;
                end
            end
            default:
            begin
                nx.st = ums_pkg::UMS_IDLE;
            end
        endcase

        // Write to a full buffer is dropped silently: no collision flag here
        if (wr_strobe && tx_on && !cur.tx_full)                         // see RULE4, RULE13
        begin
            accept     = 1'b1;
            nx.tx_buf  = wr_data;
            nx.tx_full = 1'b1;                                          // see RULE11
        end

        // Line rests high between frames
        nx.mosi = (nx.st == ums_pkg::UMS_SHIFT) ? out_bit(nx.tx_sh, bit_order_bit)
                                                : ums_pkg::LINE_IDLE;
        // Disabled transmitter keeps driving until queued work is done
        nx.drv  = active && (tx_on || nx.st == ums_pkg::UMS_SHIFT || nx.tx_full); // see RULE16

        // Transmit done: set wins over a clear in the same cycle
        nx.txc  = txc_set || (cur.txc && !txc_clear);                   // see RULE8
        nx.udre = !nx.tx_full;                                          // see RULE8
        nx.rxc  = rx_out_valid;                                         // see RULE21

        // Read returns the oldest held byte
        if (rd_strobe && rx_out_valid)
        begin
            nx.rd_data = rx_out_data;
        end

        // Error flags have no source in this mode
        nx.frm_err = 1'b0;                                              // see RULE9
        nx.ovr_err = 1'b0;
        nx.par_err = 1'b0;
    end

    // Frame completion hands the byte on; a full queue drops the newest
    assign rx_push = frame_end && rx_on;                                // see RULE7
    assign txc_set = frame_end && !cur.tx_full;

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur         <= '0;
            cur.st      <= ums_pkg::UMS_IDLE;
            cur.tx_buf  <= ums_pkg::DATA_RESET;
            cur.rd_data <= ums_pkg::DATA_RESET;
            cur.mosi    <= ums_pkg::LINE_IDLE;
            cur.udre    <= ums_pkg::EMPTY_RESET;
        end
        else
        begin
            cur <= nx;
        end
    end

    // Outputs straight from the state register
    assign rd_data            = cur.rd_data;
    assign data_empty_flag    = cur.udre;
    assign receive_done_flag  = cur.rxc;
    assign transmit_done_flag = cur.txc;
    assign framing_error_flag = cur.frm_err;
    assign overrun_flag       = cur.ovr_err;
    assign parity_error_flag  = cur.par_err;
    assign serial_out_pin     = cur.mosi;
    assign serial_out_oe      = cur.drv;
    assign transfer_clock_pin = cur.sck_pin;
    // Master only: the clock is driven whenever the data pin is, no select line
    assign transfer_clock_oe  = cur.drv;                                // see RULE15

    // Checks on the sequencer and flags
    default clocking ums_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence frame_done_s;
        active && cur.st == ums_pkg::UMS_SHIFT && tick && nx.st == ums_pkg::UMS_IDLE;
    endsequence

    sequence write_idle_s;
        cur.st == ums_pkg::UMS_IDLE && !cur.tx_full && wr_strobe && tx_on;
    endsequence

    err_flags_zero_a: // see RULE9
        assert property (!framing_error_flag && !overrun_flag && !parity_error_flag)
        else $error("error flag set in SPI mode");

    load_when_idle_a: // see RULE5
        assert property (load |-> cur.st == ums_pkg::UMS_IDLE && cur.tx_full
                                  ##1 cur.st == ums_pkg::UMS_SHIFT && !cur.tx_full)
        else $error("shifter loaded outside idle");

    write_starts_a: // see RULE4
        assert property (write_idle_s ##1 active |=> cur.st == ums_pkg::UMS_SHIFT)
        else $error("write did not start a frame");

    frame_length_a: // see RULE19
        assert property (frame_done_s |-> cur.edge_cnt == ums_pkg::EDGE_LAST
                                          ##1 transfer_clock_pin == clock_polarity_bit)
        else $error("frame ended at wrong edge");

    overflow_keep_a: // see RULE7
        assert property (rx_push && !rx_in_ready && !rd_strobe && rx_on
                         |=> rx_out_valid && rx_out_data == $past(rx_out_data))
        else $error("overflow disturbed held byte");

    txc_after_frame_a: // see RULE8
        assert property (frame_done_s ##0 !cur.tx_full |=> transmit_done_flag)
        else $error("transmit done not set");

    empty_clears_a: // see RULE11
        assert property (accept |=> !data_empty_flag)
        else $error("empty flag still set after write");

    rx_off_empty_a: // see RULE2
        assert property (!rx_on ##1 !rx_on |=> !receive_done_flag)
        else $error("receive done with receiver off");

    clock_idle_a: // see RULE10
        assert property (cur.st == ums_pkg::UMS_IDLE && active
                         |=> transfer_clock_pin == $past(clock_polarity_bit))
        else $error("idle clock level wrong");

    drive_on_a: // see RULE3
        assert property (tx_on |=> serial_out_oe && transfer_clock_oe)
        else $error("pins not driven with transmitter on");

endmodule : ums_core

/* File: verification/ums_slave.sv */
// Behavioural SPI slave model facing the serial pins of the transfer block
`timescale 1ns/1ps
module ums_slave
(
    // Serial lines
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    // Mode as programmed in the master
    input  wire logic       cpha,
    input  wire logic       lsb_first,
    // Bench side
    input  wire logic       resync,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_last,
    output int              frames
);
    int         edges = 16;
    int         nbit  = 0;
    logic [7:0] shift_in;
    logic       mosi_held;

    // Master may move the line on the very edge that closes a frame; look just before it
    always @(mosi) mosi_held <= #1 mosi;

    function automatic logic pick(input logic [7:0] b, input int i);
        return lsb_first ? b[i] : b[7-i];
    endfunction : pick

    initial
    begin
        miso    = 1'h0;
        frames  = 0;
        rx_last = 8'h00;
    end

    // No select line, so the bench marks frame alignment while the clock idles
    always @(posedge resync)
    begin
        edges = 0;
        nbit  = 0;
        miso  = cpha ? ~miso : pick(tx_byte, 0);
    end

    // Sample on one edge, shift on the other; a released line shows the inverse
    always @(sclk)
    begin
        if (edges < 16 && resync == 1'h0)
        begin
            if (((edges % 2) == 0) != (cpha == 1'h1))
            begin
                shift_in[lsb_first ? nbit : 7 - nbit] = mosi_held;
                nbit = nbit + 1;
            end
            else if (nbit < 8)
                miso = pick(tx_byte, nbit);
            edges = edges + 1;
            if (edges == 16)
            begin
                rx_last = shift_in;
                frames  = frames + 1;
                edges   = 0;
                nbit    = 0;
                miso    = cpha ? ~miso : pick(tx_byte, 0);
            end
        end
    end
endmodule : ums_slave

/* File: verification/test_usart_master_spi_transfer.sv */
// Self-checking bench for the master SPI transfer block
`timescale 1ns/1ps
module test_usart_master_spi_transfer;
    // Design side
    logic       clk_sys = 1'h0;
    logic       rst_n;
    logic [1:0] mode;
    logic       tx_en;
    logic       rx_en;
    logic       cpol;
    logic       cpha;
    logic       order;
    logic       wr_strobe;
    logic [7:0] wr_data;
    logic [11:0] baud;
    logic       rd_strobe;
    logic       txc_clear;
    logic [7:0] rd_data;
    logic       empty;
    logic       rx_done;
    logic       tx_done;
    logic       flag_frame;
    logic       flag_over;
    logic       flag_par;
    logic       sout;
    logic       sout_oe;
    logic       sin;
    logic       sclk;
    logic       sclk_oe;
    // Partner side
    logic       resync;
    logic [7:0] slave_tx;
    logic [7:0] slave_rx;
    int         slave_frames;
    int         err_total;
    int         comparisons;

    always #5 clk_sys = ~clk_sys;

    ums_core DUT (.clk_sys(clk_sys), .rst_n(rst_n), .transceiver_mode_select(mode),
        .tx_enable_bit(tx_en), .rx_enable_bit(rx_en), .clock_polarity_bit(cpol),
        .clock_phase_bit(cpha), .bit_order_bit(order), .baud_divisor(baud),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .txc_clear(txc_clear), .data_empty_flag(empty), .receive_done_flag(rx_done),
        .transmit_done_flag(tx_done), .framing_error_flag(flag_frame),
        .overrun_flag(flag_over), .parity_error_flag(flag_par), .serial_out_pin(sout),
        .serial_out_oe(sout_oe), .serial_in_pin(sin), .transfer_clock_pin(sclk),
        .transfer_clock_oe(sclk_oe));

    ums_slave slave (.sclk(sclk), .mosi(sout), .miso(sin), .cpha(cpha), .lsb_first(order),
        .resync(resync), .tx_byte(slave_tx), .rx_last(slave_rx), .frames(slave_frames));

    // Slave answers a fresh byte in every frame, so a dropped one is visible
    always @(slave_frames) slave_tx <= slave_tx + 8'h11;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    // Bounded wait: 0 empty, 1 receive done, 2 transmit done
    task automatic wait_flag(input int sel);
        int n;
        n = 0;
        #1;
        while (n < 3000 && !((sel == 0 && empty === 1'h1) || (sel == 1 && rx_done === 1'h1)
               || (sel == 2 && tx_done === 1'h1)))
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 3000) check(8'h00, 8'h01, "flag wait timed out");
    endtask : wait_flag

    task automatic write_byte(input logic [7:0] b);
        @(posedge clk_sys);
        wr_strobe <= 1'h1;
        wr_data   <= b;
        @(posedge clk_sys);
        wr_strobe <= 1'h0;
        #1;
    endtask : write_byte

    task automatic read_byte(output logic [7:0] b);
        @(posedge clk_sys);
        rd_strobe <= 1'h1;
        @(posedge clk_sys);
        rd_strobe <= 1'h0;
        @(posedge clk_sys);
        #1;
        b = rd_data;
    endtask : read_byte

    // Realign the slave while the clock idles
    task automatic resync_slave(input logic [7:0] sb);
        @(posedge clk_sys);
        slave_tx <= sb;
        @(posedge clk_sys);
        resync   <= 1'h1;
        repeat (3) @(posedge clk_sys);
        resync <= 1'h0;
    endtask : resync_slave

    task automatic clear_txc;
        @(posedge clk_sys);
        txc_clear <= 1'h1;
        @(posedge clk_sys);
        txc_clear <= 1'h0;
        @(posedge clk_sys);
        #1;
        check(tx_done, 1'h0, "transmit done not cleared");
    endtask : clear_txc

    task automatic xfer(input logic [7:0] tx, input logic [7:0] sb);
        logic [7:0] got;
        resync_slave(sb);
        write_byte(tx);
        wait_flag(1);
        check(slave_rx, tx, "slave got wrong byte");
        read_byte(got);
        check(got, sb, "read wrong byte");
    endtask : xfer

    task automatic test_reset;
        check(empty, 1'h1, "empty flag after reset");
        check({flag_frame, flag_over, flag_par}, 3'h0, "error flags set");
        check(sout, 1'h1, "data line not idle");
        check(sclk_oe, 1'h1, "clock pin not driven");
        $display("test reset finished");
    endtask : test_reset

    // All four clock modes, both bit orders
    task automatic test_modes;
        for (int m = 0; m < 8; m++)
        begin
            @(posedge clk_sys);
            cpol  <= m[0];
            cpha  <= m[1];
            order <= m[2];
            baud  <= (m < 4) ? 12'h005 : 12'h002;
            repeat (3) @(posedge clk_sys);
            #1;
            check(sclk, cpol, "clock idle level");
            xfer(8'hA5 ^ 8'(m * 19), 8'h3C + 8'(m));
            check({flag_frame, flag_over, flag_par}, 3'h0, "error flags set");
        end
        check(tx_done, 1'h1, "transmit done missing");
        clear_txc();
        $display("test modes finished");
    endtask : test_modes

    // Three queued bytes with no read: third received byte is lost
    task automatic test_queue;
        logic [7:0] got;
        @(posedge clk_sys);
        cpol  <= 1'h0;
        cpha  <= 1'h1;
        order <= 1'h0;
        resync_slave(8'h10);
        write_byte(8'hC1);
        wait_flag(0);
        write_byte(8'hC2);
        check(empty, 1'h0, "second byte not queued");
        check(tx_done, 1'h0, "done while shifting");
        wait_flag(0);
        write_byte(8'hC3);
        wait_flag(2);
        check(slave_rx, 8'hC3, "last byte not sent");
        check(flag_over, 1'h0, "overrun flag set");
        read_byte(got);
        check(got, 8'h10, "oldest byte lost");
        read_byte(got);
        check(got, 8'h21, "second byte lost");
        check(rx_done, 1'h0, "newest byte kept");
        clear_txc();
        $display("test queue finished");
    endtask : test_queue

    // Disabled transmitter, receiver and wrong mode
    task automatic test_disable;
        @(posedge clk_sys);
        tx_en <= 1'h0;
        repeat (2) @(posedge clk_sys);
        write_byte(8'h77);
        repeat (60) @(posedge clk_sys);
        #1;
        check(sout_oe, 1'h0, "pin driven while disabled");
        check(empty, 1'h1, "write taken while disabled");
        check(tx_done, 1'h0, "frame sent while disabled");
        @(posedge clk_sys);
        tx_en <= 1'h1;
        resync_slave(8'h55);
        write_byte(8'h66);
        wait_flag(1);
        check(sout_oe, 1'h1, "data pin not driven");
        @(posedge clk_sys);
        rx_en <= 1'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(rx_done, 1'h0, "queue kept after disable");
        @(posedge clk_sys);
        rx_en <= 1'h1;
        clear_txc();
        @(posedge clk_sys);
        mode <= 2'h1;
        write_byte(8'h99);
        repeat (60) @(posedge clk_sys);
        #1;
        check(tx_done, 1'h0, "frame sent in other mode");
        @(posedge clk_sys);
        mode <= 2'h3;
        $display("test disable finished");
    endtask : test_disable

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // Watchdog, far beyond the expected run of about a thousand cycles
    initial
    begin
        #300000;
        err_total++;
        results();
    end

    // Main sequence
    initial
    begin
        err_total   = 0;
        comparisons = 0;
        rst_n       = 1'h0;
        mode        = 2'h3;
        baud        = 12'h005;
        tx_en       = 1'h1;
        rx_en       = 1'h1;
        cpol        = 1'h0;
        cpha        = 1'h0;
        order       = 1'h0;
        wr_strobe   = 1'h0;
        wr_data     = 8'h00;
        rd_strobe   = 1'h0;
        txc_clear   = 1'h0;
        resync      = 1'h0;
        slave_tx    = 8'h00;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        test_reset();
        test_modes();
        test_queue();
        test_disable();
        results();
    end
endmodule : test_usart_master_spi_transfer
